// *** tmb_defines.svh ***
// register map, fields and prescaler taps of the timer channel
// assumes inclusion by bare name
`ifndef TMB_DEFINES_SVH
`define TMB_DEFINES_SVH

`define TMB_ADDR_W        8
`define TMB_OFF_RUN       8'h00
`define TMB_OFF_MODE      8'h04
`define TMB_OFF_FFCR      8'h08
`define TMB_OFF_CMP0      8'h0c
`define TMB_OFF_CMP1      8'h10
`define TMB_OFF_CAP0      8'h14
`define TMB_OFF_CAP1      8'h18
`define TMB_OFF_COUNT     8'h1c
`define TMB_OFF_SWCAP     8'h20

`define TMB_RUN_BIT       0
`define TMB_PRUN_BIT      2
`define TMB_MODE_CLK_LO   0
`define TMB_MODE_CLK_HI   1
`define TMB_MODE_CLE_BIT  2
`define TMB_MODE_CPM_LO   3
`define TMB_MODE_CPM_HI   4
`define TMB_FF_CTL_LO     0
`define TMB_FF_CTL_HI     1
`define TMB_FF_E0_BIT     2
`define TMB_FF_E1_BIT     3
`define TMB_FF_DBUF_BIT   4
`define TMB_SWCAP_BIT     0

`define TMB_CNT_ZERO      16'h0000
`define TMB_CNT_ONE       16'h0001
`define TMB_WORD_ZERO     32'h0000_0000
`define TMB_FF_CTL_READ   2'h3

`define TMB_PRE_W         5
`define TMB_PRE_ONE       5'h01
`define TMB_PRE_MASK_T1   5'h01
`define TMB_PRE_MASK_T4   5'h07
`define TMB_PRE_MASK_T16  5'h1f

`endif

// *** tmb_pkg.sv ***
// types shared by the timer channel modules
// assumes nothing
`default_nettype none
package tmb_pkg;
    typedef enum logic [1:0] {TMB_CLK_EXT, TMB_CLK_T1, TMB_CLK_T4, TMB_CLK_T16} tmb_clk_e;
    typedef enum logic [1:0] {TMB_CAP_OFF, TMB_CAP_PINS, TMB_CAP_IN0_EDGES, TMB_CAP_COMPANION} tmb_cap_e;
    typedef enum logic [1:0] {TMB_FF_INVERT, TMB_FF_SET, TMB_FF_CLEAR, TMB_FF_KEEP} tmb_ffc_e;
    typedef logic [15:0] tmb_word_t;
endpackage : tmb_pkg
`default_nettype wire

// *** tmb_presc_if.sv ***
// prescaler run request and tick enables
// assumes one clock domain on both ends
`default_nettype none
interface tmb_presc_if;
    logic       run;
    logic [2:0] tick;
    modport src (input run, output tick);
    modport dst (output run, input tick);
endinterface : tmb_presc_if
`default_nettype wire

// *** tmb_prescaler.sv ***
// divider making tick enables for three taps
// assumes the parent drives run from the prescaler run bit
`include "tmb_defines.svh"
`default_nettype none
module tmb_prescaler
    import tmb_pkg::*;
(
    input  wire logic      CLK,
    input  wire logic      RST_N,
    tmb_presc_if.src       pif
);
    logic [`TMB_PRE_W-1:0] div;
    logic [`TMB_PRE_W-1:0] next_div;
    logic [2:0]            next_tick;
    logic [2:0]            tick;

    // restart from zero keeps the first tick period whole
    always_comb begin
        next_div  = pif.run ? div + `TMB_PRE_ONE : {`TMB_PRE_W{1'b0}};
        next_tick = 3'h0;
        if (pif.run) begin
            next_tick[0] = (div & `TMB_PRE_MASK_T1) == `TMB_PRE_MASK_T1;
            next_tick[1] = (div & `TMB_PRE_MASK_T4) == `TMB_PRE_MASK_T4;
            next_tick[2] = (div & `TMB_PRE_MASK_T16) == `TMB_PRE_MASK_T16;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            div  <= {`TMB_PRE_W{1'b0}};
            tick <= 3'h0;
        end else begin
            div  <= next_div;
            tick <= next_tick;
        end
    end

    assign pif.tick = tick;
endmodule : tmb_prescaler
`default_nettype wire

// *** tmb_channel.sv ***
// 16-bit timer channel: counter, compares, captures, output flop, APB
// assumes pins and companion flop are synchronous to CLK; APB slave with no wait states
// Function
// - interrupt when counter reaches compare one
// - interval mode counts prescaler, capture off
// - event mode counts input zero rising edges
// - software command copies counter to capture zero
// - compare matches toggle flop driving output pin
// - buffered compare zero loads on match one
// - output polarity free via flop set/clear
// - control 11: companion edges load captures
// - control 10: input zero edges load captures
// - input zero irq edge depends on control
// - input zero rise captures zero, raises irq
// - input one rise captures one, raises irq
// - clear-enable chooses clear on match one
// - flop control: invert, set, clear, keep
//
// Local design decisions: the APB register port and the register addresses.
`include "tmb_defines.svh"
`default_nettype none
module tmb_channel
    import tmb_pkg::*;
(
    input  wire logic                   CLK,
    input  wire logic                   RST_N,
    input  wire logic                   PSEL,
    input  wire logic                   PENABLE,
    input  wire logic                   PWRITE,
    input  wire logic [`TMB_ADDR_W-1:0] PADDR,
    input  wire logic [31:0]            PWDATA,
    output logic [31:0]                 PRDATA,
    output logic                        PREADY,
    output logic                        PSLVERR,
    input  wire logic                   EXTERNAL_INPUT_ZERO,
    input  wire logic                   EXTERNAL_INPUT_ONE,
    input  wire logic                   COMPANION_TIMER_FLOP,
    output logic                        TIMER_OUTPUT_PIN,
    output logic                        COMPARE_ZERO_INTERRUPT,
    output logic                        COMPARE_ONE_INTERRUPT,
    output logic                        INPUT_ZERO_EXT_INTERRUPT,
    output logic                        INPUT_ONE_EXT_INTERRUPT
);
    tmb_presc_if pif ();

    tmb_prescaler u_presc (
        .CLK   (CLK),
        .RST_N (RST_N),
        .pif   (pif)
    );

    function automatic logic rise(input logic now, input logic was);
        rise = now & ~was;
    endfunction : rise

    function automatic logic hit(input logic [`TMB_ADDR_W-1:0] addr, input logic [`TMB_ADDR_W-1:0] off);
        hit = (addr == off);
    endfunction : hit

    // control registers
    logic        run_bit;
    logic        prescaler_run_bit;
    tmb_clk_e    clk_sel;
    logic        clear_en;
    tmb_cap_e    capture_control_field;
    logic        toggle_on_match_zero_enable;
    logic        toggle_on_match_one_enable;
    logic        dbuf_en;
    tmb_word_t   compare_reg_zero;
    tmb_word_t   compare_buf;
    tmb_word_t   compare_reg_one;
    logic        next_run_bit;
    logic        next_prescaler_run_bit;
    tmb_clk_e    next_clk_sel;
    logic        next_clear_en;
    tmb_cap_e    next_capture_control_field;
    logic        next_toggle_on_match_zero_enable;
    logic        next_toggle_on_match_one_enable;
    logic        next_dbuf_en;
    tmb_word_t   next_compare_reg_zero;
    tmb_word_t   next_compare_buf;
    tmb_word_t   next_compare_reg_one;

    // timing state
    tmb_word_t   up_counter;
    tmb_word_t   capture_reg_zero;
    tmb_word_t   capture_reg_one;
    logic        output_toggle_flop;
    logic        in0_q;
    logic        in1_q;
    logic        comp_q;
    logic        cmp0_irq;
    logic        cmp1_irq;
    logic        in0_irq;
    logic        in1_irq;
    tmb_word_t   next_up_counter;
    tmb_word_t   next_capture_reg_zero;
    tmb_word_t   next_capture_reg_one;
    logic        next_output_toggle_flop;
    logic        next_cmp0_irq;
    logic        next_cmp1_irq;
    logic        next_in0_irq;
    logic        next_in1_irq;

    // bus
    logic [31:0] prdata;
    logic [31:0] next_prdata;

    logic        wr;
    logic        setup;
    logic        mapped;
    logic        in0_rise;
    logic        in0_fall;
    logic        in1_rise;
    logic        comp_rise;
    logic        comp_fall;
    logic        count_tick;
    logic        match0;
    logic        match1;
    logic        sw_cap;

    assign wr    = PSEL & PENABLE & PWRITE;
    assign setup = PSEL & ~PENABLE;
    assign pif.run = prescaler_run_bit;

    always_comb begin
        mapped = hit(PADDR, `TMB_OFF_RUN) | hit(PADDR, `TMB_OFF_MODE) | hit(PADDR, `TMB_OFF_FFCR)
               | hit(PADDR, `TMB_OFF_CMP0) | hit(PADDR, `TMB_OFF_CMP1) | hit(PADDR, `TMB_OFF_CAP0)
               | hit(PADDR, `TMB_OFF_CAP1) | hit(PADDR, `TMB_OFF_COUNT) | hit(PADDR, `TMB_OFF_SWCAP);
    end

    assign in0_rise  = rise(EXTERNAL_INPUT_ZERO, in0_q);
    assign in0_fall  = rise(in0_q, EXTERNAL_INPUT_ZERO);
    assign in1_rise  = rise(EXTERNAL_INPUT_ONE, in1_q);
    assign comp_rise = rise(COMPANION_TIMER_FLOP, comp_q);
    assign comp_fall = rise(comp_q, COMPANION_TIMER_FLOP);
    assign sw_cap    = wr & hit(PADDR, `TMB_OFF_SWCAP) & PWDATA[`TMB_SWCAP_BIT];

    // register writes
    always_comb begin
        next_run_bit                     = run_bit;
        next_prescaler_run_bit           = prescaler_run_bit;
        next_clk_sel                     = clk_sel;
        next_clear_en                    = clear_en;
        next_capture_control_field       = capture_control_field;
        next_toggle_on_match_zero_enable = toggle_on_match_zero_enable;
        next_toggle_on_match_one_enable  = toggle_on_match_one_enable;
        next_dbuf_en                     = dbuf_en;
        next_compare_buf                 = compare_buf;
        next_compare_reg_one             = compare_reg_one;
        next_compare_reg_zero            = compare_reg_zero;
        if (wr) begin
            if (hit(PADDR, `TMB_OFF_RUN)) begin
                next_run_bit           = PWDATA[`TMB_RUN_BIT];
                next_prescaler_run_bit = PWDATA[`TMB_PRUN_BIT];
            end
            if (hit(PADDR, `TMB_OFF_MODE)) begin
                next_clk_sel               = tmb_clk_e'(PWDATA[`TMB_MODE_CLK_HI:`TMB_MODE_CLK_LO]);
                next_clear_en              = PWDATA[`TMB_MODE_CLE_BIT];
                next_capture_control_field = tmb_cap_e'(PWDATA[`TMB_MODE_CPM_HI:`TMB_MODE_CPM_LO]);
            end
            if (hit(PADDR, `TMB_OFF_FFCR)) begin
                next_toggle_on_match_zero_enable = PWDATA[`TMB_FF_E0_BIT];
                next_toggle_on_match_one_enable  = PWDATA[`TMB_FF_E1_BIT];
                next_dbuf_en                     = PWDATA[`TMB_FF_DBUF_BIT];
            end
            if (hit(PADDR, `TMB_OFF_CMP0)) begin
                next_compare_buf = PWDATA[15:0];
            end
            if (hit(PADDR, `TMB_OFF_CMP1)) begin
                next_compare_reg_one = PWDATA[15:0];
            end
        end
        // buffered writes wait for match one
        if (wr && hit(PADDR, `TMB_OFF_CMP0) && !dbuf_en) begin
            next_compare_reg_zero = PWDATA[15:0];
        end else if (dbuf_en && match1) begin
            next_compare_reg_zero = compare_buf;
        end
    end

    // counter, compares and captures
    always_comb begin
        unique case (clk_sel)
            TMB_CLK_T1:  count_tick = pif.tick[0];
            TMB_CLK_T4:  count_tick = pif.tick[1];
            TMB_CLK_T16: count_tick = pif.tick[2];
            // count on input zero rising edge
            TMB_CLK_EXT: count_tick = in0_rise;
        endcase
        // prescaler run gates external counting too
        count_tick = count_tick & run_bit & prescaler_run_bit;

        next_up_counter = up_counter;
        if (!run_bit) begin
            next_up_counter = `TMB_CNT_ZERO;
        end else if (count_tick) begin
            // clear on match one if enabled
            if (clear_en && up_counter == compare_reg_one) begin
                next_up_counter = `TMB_CNT_ZERO;
            end else begin
                next_up_counter = up_counter + `TMB_CNT_ONE;
            end
        end
        match0 = count_tick && next_up_counter == compare_reg_zero;
        match1 = count_tick && next_up_counter == compare_reg_one;

        next_capture_reg_zero = capture_reg_zero;
        next_capture_reg_one  = capture_reg_one;
        unique case (capture_control_field)
            TMB_CAP_OFF: begin
            end
            TMB_CAP_PINS: begin
                if (in0_rise) next_capture_reg_zero = up_counter;
                if (in1_rise) next_capture_reg_one = up_counter;
            end
            TMB_CAP_IN0_EDGES: begin
                if (in0_rise) next_capture_reg_zero = up_counter;
                if (in0_fall) next_capture_reg_one = up_counter;
            end
            TMB_CAP_COMPANION: begin
                if (comp_rise) next_capture_reg_zero = up_counter;
                if (comp_fall) next_capture_reg_one = up_counter;
            end
        endcase
        // software capture wins over a pin edge
        if (sw_cap) next_capture_reg_zero = up_counter;

        next_cmp0_irq = match0;
        next_cmp1_irq = match1;
        // falling edge only in control 10
        next_in0_irq  = (capture_control_field == TMB_CAP_IN0_EDGES) ? in0_fall : in0_rise;
        next_in1_irq  = in1_rise;
    end

    // output flop: software invert, set or clear beats a match; keep lets it toggle
    always_comb begin
        next_output_toggle_flop = output_toggle_flop;
        if ((match0 && toggle_on_match_zero_enable) ^ (match1 && toggle_on_match_one_enable)) begin
            next_output_toggle_flop = ~output_toggle_flop;
        end
        if (wr && hit(PADDR, `TMB_OFF_FFCR)) begin
            unique case (tmb_ffc_e'(PWDATA[`TMB_FF_CTL_HI:`TMB_FF_CTL_LO]))
                TMB_FF_INVERT: next_output_toggle_flop = ~output_toggle_flop;
                TMB_FF_SET:    next_output_toggle_flop = 1'b1;
                TMB_FF_CLEAR:  next_output_toggle_flop = 1'b0;
                TMB_FF_KEEP:   ;
            endcase
        end
    end

    // read data latched in setup: no wait state
    always_comb begin
        next_prdata = prdata;
        if (setup && !PWRITE) begin
            next_prdata = `TMB_WORD_ZERO;
            if (hit(PADDR, `TMB_OFF_RUN)) begin
                next_prdata[`TMB_RUN_BIT]  = run_bit;
                next_prdata[`TMB_PRUN_BIT] = prescaler_run_bit;
            end
            if (hit(PADDR, `TMB_OFF_MODE)) begin
                next_prdata[`TMB_MODE_CLK_HI:`TMB_MODE_CLK_LO] = clk_sel;
                next_prdata[`TMB_MODE_CLE_BIT]                 = clear_en;
                next_prdata[`TMB_MODE_CPM_HI:`TMB_MODE_CPM_LO] = capture_control_field;
            end
            if (hit(PADDR, `TMB_OFF_FFCR)) begin
                next_prdata[`TMB_FF_CTL_HI:`TMB_FF_CTL_LO] = `TMB_FF_CTL_READ;
                next_prdata[`TMB_FF_E0_BIT]                = toggle_on_match_zero_enable;
                next_prdata[`TMB_FF_E1_BIT]                = toggle_on_match_one_enable;
                next_prdata[`TMB_FF_DBUF_BIT]              = dbuf_en;
            end
            if (hit(PADDR, `TMB_OFF_CMP0))  next_prdata[15:0] = compare_reg_zero;
            if (hit(PADDR, `TMB_OFF_CMP1))  next_prdata[15:0] = compare_reg_one;
            if (hit(PADDR, `TMB_OFF_CAP0))  next_prdata[15:0] = capture_reg_zero;
            if (hit(PADDR, `TMB_OFF_CAP1))  next_prdata[15:0] = capture_reg_one;
            if (hit(PADDR, `TMB_OFF_COUNT)) next_prdata[15:0] = up_counter;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            run_bit                     <= 1'b0;
            prescaler_run_bit           <= 1'b0;
            clk_sel                     <= TMB_CLK_EXT;
            clear_en                    <= 1'b0;
            capture_control_field       <= TMB_CAP_OFF;
            toggle_on_match_zero_enable <= 1'b0;
            toggle_on_match_one_enable  <= 1'b0;
            dbuf_en                     <= 1'b0;
            compare_reg_zero            <= `TMB_CNT_ZERO;
            compare_buf                 <= `TMB_CNT_ZERO;
            compare_reg_one             <= `TMB_CNT_ZERO;
            up_counter                  <= `TMB_CNT_ZERO;
            capture_reg_zero            <= `TMB_CNT_ZERO;
            capture_reg_one             <= `TMB_CNT_ZERO;
            output_toggle_flop          <= 1'b0;
            in0_q                       <= 1'b0;
            in1_q                       <= 1'b0;
            comp_q                      <= 1'b0;
            cmp0_irq                    <= 1'b0;
            cmp1_irq                    <= 1'b0;
            in0_irq                     <= 1'b0;
            in1_irq                     <= 1'b0;
            prdata                      <= `TMB_WORD_ZERO;
        end else begin
            run_bit                     <= next_run_bit;
            prescaler_run_bit           <= next_prescaler_run_bit;
            clk_sel                     <= next_clk_sel;
            clear_en                    <= next_clear_en;
            capture_control_field       <= next_capture_control_field;
            toggle_on_match_zero_enable <= next_toggle_on_match_zero_enable;
            toggle_on_match_one_enable  <= next_toggle_on_match_one_enable;
            dbuf_en                     <= next_dbuf_en;
            compare_reg_zero            <= next_compare_reg_zero;
            compare_buf                 <= next_compare_buf;
            compare_reg_one             <= next_compare_reg_one;
            up_counter                  <= next_up_counter;
            capture_reg_zero            <= next_capture_reg_zero;
            capture_reg_one             <= next_capture_reg_one;
            output_toggle_flop          <= next_output_toggle_flop;
            in0_q                       <= EXTERNAL_INPUT_ZERO;
            in1_q                       <= EXTERNAL_INPUT_ONE;
            comp_q                      <= COMPANION_TIMER_FLOP;
            cmp0_irq                    <= next_cmp0_irq;
            cmp1_irq                    <= next_cmp1_irq;
            in0_irq                     <= next_in0_irq;
            in1_irq                     <= next_in1_irq;
            prdata                      <= next_prdata;
        end
    end

    assign PRDATA                   = prdata;
    assign PREADY                   = 1'b1;
    assign PSLVERR                  = PSEL & PENABLE & ~mapped;
    assign TIMER_OUTPUT_PIN         = output_toggle_flop;
    assign COMPARE_ZERO_INTERRUPT   = cmp0_irq;
    assign COMPARE_ONE_INTERRUPT    = cmp1_irq;
    assign INPUT_ZERO_EXT_INTERRUPT = in0_irq;
    assign INPUT_ONE_EXT_INTERRUPT  = in1_irq;
endmodule : tmb_channel
`default_nettype wire

// *** tmb_pulse_model.sv ***
// pin-side model: inputs zero, one and companion flop
// assumes the channel clock; driven by bench tasks
`default_nettype none
module tmb_pulse_model (
    input  wire logic clk,
    output logic      in_zero,
    output logic      in_one,
    output logic      comp_flop
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        in_zero   = 1'b0;
        in_one    = 1'b0;
        comp_flop = 1'b0;
    end
    // two cycles high, three low between pulses and two after the last, so no edge is missed
    task automatic pulse(input logic sel, input int n);
        repeat (n) begin
            @(posedge clk);
            if (sel) in_one <= 1'b1;
            else in_zero <= 1'b1;
            repeat (2) @(posedge clk);
            in_one  <= 1'b0;
            in_zero <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask : pulse
    task automatic set_comp(input logic v);
        @(posedge clk);
        comp_flop <= v;
        repeat (2) @(posedge clk);
    endtask : set_comp
endmodule : tmb_pulse_model
`default_nettype wire

// *** tmb_channel_monitor.sv ***
// checker on channel ports
// assumes pins synchronous to CLK
`include "tmb_defines.svh"
`default_nettype none
module tmb_channel_monitor (
    input wire logic                   CLK,
    input wire logic                   RST_N,
    input wire logic                   PSEL,
    input wire logic                   PENABLE,
    input wire logic                   PWRITE,
    input wire logic [`TMB_ADDR_W-1:0] PADDR,
    input wire logic [31:0]            PWDATA,
    input wire logic [31:0]            PRDATA,
    input wire logic                   PREADY,
    input wire logic                   PSLVERR,
    input wire logic                   EXTERNAL_INPUT_ZERO,
    input wire logic                   EXTERNAL_INPUT_ONE,
    input wire logic                   TIMER_OUTPUT_PIN,
    input wire logic                   COMPARE_ZERO_INTERRUPT,
    input wire logic                   COMPARE_ONE_INTERRUPT,
    input wire logic                   INPUT_ZERO_EXT_INTERRUPT,
    input wire logic                   INPUT_ONE_EXT_INTERRUPT
);
    logic [1:0] cpm;
    logic       acc;
    logic       unm;
    logic       ffw;
    assign acc = PSEL && PENABLE && PREADY;
    assign unm = PADDR > `TMB_OFF_SWCAP || PADDR[1:0] != 2'h0;
    assign ffw = acc && PWRITE && PADDR == `TMB_OFF_FFCR;
    // capture control shadow
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cpm <= 2'h0;
        end else if (acc && PWRITE && PADDR == `TMB_OFF_MODE) begin
            cpm <= PWDATA[`TMB_MODE_CPM_HI:`TMB_MODE_CPM_LO];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_err_decode: assert property (PSEL && PENABLE |-> PSLVERR == unm)
        else $error("bad slverr");
    a_unm_read_zero: assert property (PSEL && PENABLE && !PWRITE && unm |-> PRDATA == 32'h0)
        else $error("unmapped read");
    a_in0_rise_irq: assert property ($rose(EXTERNAL_INPUT_ZERO) && cpm != 2'h2 |=> INPUT_ZERO_EXT_INTERRUPT)
        else $error("in0 rise no irq");
    a_in0_fall_irq: assert property ($fell(EXTERNAL_INPUT_ZERO) && cpm == 2'h2 |=> INPUT_ZERO_EXT_INTERRUPT)
        else $error("in0 fall no irq");
    a_in0_irq_cause: assert property (INPUT_ZERO_EXT_INTERRUPT |-> $past(EXTERNAL_INPUT_ZERO)
        != $past(EXTERNAL_INPUT_ZERO, 2) && $past(EXTERNAL_INPUT_ZERO) == ($past(cpm) != 2'h2))
        else $error("in0 irq wrong edge");
    a_in1_rise_irq: assert property ($rose(EXTERNAL_INPUT_ONE) |=> INPUT_ONE_EXT_INTERRUPT)
        else $error("in1 rise no irq");
    a_flop_set: assert property (ffw && PWDATA[1:0] == 2'h1 |=> TIMER_OUTPUT_PIN)
        else $error("set missed");
    a_flop_clear: assert property (ffw && PWDATA[1:0] == 2'h2 |=> !TIMER_OUTPUT_PIN)
        else $error("clear missed");
    a_flop_invert: assert property (ffw && PWDATA[1:0] == 2'h0 |=> TIMER_OUTPUT_PIN != $past(TIMER_OUTPUT_PIN))
        else $error("invert missed");
    a_cmp1_pulse: assert property (COMPARE_ONE_INTERRUPT |=> !COMPARE_ONE_INTERRUPT)
        else $error("cmp1 irq too long");
    a_cmp0_pulse: assert property (COMPARE_ZERO_INTERRUPT |=> !COMPARE_ZERO_INTERRUPT)
        else $error("cmp0 irq too long");
    c_cmp1: cover property (COMPARE_ONE_INTERRUPT);
    c_in0_fall: cover property ($fell(EXTERNAL_INPUT_ZERO) && cpm == 2'h2);
    c_pin_rise: cover property ($rose(TIMER_OUTPUT_PIN) && !ffw);
endmodule : tmb_channel_monitor
bind tmb_channel tmb_channel_monitor mon_u (.CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .EXTERNAL_INPUT_ZERO, .EXTERNAL_INPUT_ONE, .TIMER_OUTPUT_PIN, .COMPARE_ONE_INTERRUPT,
    .COMPARE_ZERO_INTERRUPT, .INPUT_ZERO_EXT_INTERRUPT, .INPUT_ONE_EXT_INTERRUPT);
`default_nettype wire

// *** tmb_channel_tb.sv ***
// bench for the timer channel, one task per scenario
// assumes a synchronous channel
`include "tmb_defines.svh"
`default_nettype none
module tmb_channel_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   clk, rst_n, psel, penable, pwrite, in0, in1, comp;
    logic                   pready, pslverr, pin, pin_q, c1i, err;
    logic [`TMB_ADDR_W-1:0] paddr;
    logic [31:0]            pwdata, prdata, q;
    int                     n_fail = 0, tests_run = 0, n_c1 = 0, n_tog = 0;
    tmb_channel dut_u (
        .CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EXTERNAL_INPUT_ZERO(in0), .EXTERNAL_INPUT_ONE(in1), .COMPANION_TIMER_FLOP(comp),
        .TIMER_OUTPUT_PIN(pin), .COMPARE_ZERO_INTERRUPT(), .COMPARE_ONE_INTERRUPT(c1i),
        .INPUT_ZERO_EXT_INTERRUPT(), .INPUT_ONE_EXT_INTERRUPT());
    tmb_pulse_model model_u (.clk(clk), .in_zero(in0), .in_one(in1), .comp_flop(comp));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        pin_q <= pin;
        if (c1i === 1'b1) n_c1 <= n_c1 + 1;
        if (pin !== pin_q) n_tog <= n_tog + 1;
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [`TMB_ADDR_W-1:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic rdchk(input logic [`TMB_ADDR_W-1:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rdchk
    // reconfigure only while stopped
    task automatic start(input logic [31:0] mode);
        apb(1'b1, `TMB_OFF_RUN, 32'h0);
        apb(1'b1, `TMB_OFF_MODE, mode);
        apb(1'b1, `TMB_OFF_RUN, 32'h5);
    endtask : start
    task automatic wait_c1(output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (c1i !== 1'b1 && k < 500);
    endtask : wait_c1
    task automatic t_regs;
        rdchk(`TMB_OFF_RUN, 32'h0);
        rdchk(`TMB_OFF_FFCR, 32'h3);
        apb(1'b1, `TMB_OFF_CAP0, 32'hffff);
        rdchk(`TMB_OFF_CAP0, 32'h0);
        apb(1'b1, `TMB_OFF_CMP1, 32'habcd_1234);
        rdchk(`TMB_OFF_CMP1, 32'h1234);
        rdchk(8'h24, 32'h0);
        chk({31'h0, err}, 32'h1);
    endtask : t_regs
    task automatic t_flop;
        apb(1'b1, `TMB_OFF_FFCR, 32'h1);
        chk({31'h0, pin}, 32'h1);
        apb(1'b1, `TMB_OFF_FFCR, 32'h2);
        chk({31'h0, pin}, 32'h0);
        apb(1'b1, `TMB_OFF_FFCR, 32'h0);
        chk({31'h0, pin}, 32'h1);
        apb(1'b1, `TMB_OFF_FFCR, 32'h3);
        chk({31'h0, pin}, 32'h1);
    endtask : t_flop
    task automatic t_interval;
        int a;
        apb(1'b1, `TMB_OFF_CMP1, 32'h3);
        start(32'h5);
        wait_c1(a);
        wait_c1(a);
        chk(a, 8);
        model_u.pulse(1'b1, 1);
        rdchk(`TMB_OFF_CAP1, 32'h0);
    endtask : t_interval
    task automatic t_event;
        int k;
        start(32'h4);
        model_u.pulse(1'b0, 2);
        rdchk(`TMB_OFF_COUNT, 32'h2);
        apb(1'b1, `TMB_OFF_SWCAP, 32'h1);
        rdchk(`TMB_OFF_CAP0, 32'h2);
        k = n_c1;
        model_u.pulse(1'b0, 1);
        chk(n_c1 - k, 1);
        model_u.pulse(1'b0, 1);
        rdchk(`TMB_OFF_COUNT, 32'h0);
    endtask : t_event
    task automatic t_pins;
        start(32'h08);
        model_u.pulse(1'b0, 3);
        model_u.pulse(1'b1, 1);
        rdchk(`TMB_OFF_CAP0, 32'h2);
        rdchk(`TMB_OFF_CAP1, 32'h3);
    endtask : t_pins
    task automatic t_in0_edges;
        start(32'h10);
        model_u.pulse(1'b0, 2);
        rdchk(`TMB_OFF_CAP0, 32'h1);
        rdchk(`TMB_OFF_CAP1, 32'h2);
    endtask : t_in0_edges
    task automatic t_companion;
        start(32'h18);
        model_u.pulse(1'b0, 2);
        model_u.set_comp(1'b1);
        model_u.pulse(1'b0, 3);
        model_u.set_comp(1'b0);
        rdchk(`TMB_OFF_CAP0, 32'h2);
        rdchk(`TMB_OFF_CAP1, 32'h5);
    endtask : t_companion
    task automatic t_ppg;
        int a;
        int t;
        apb(1'b1, `TMB_OFF_RUN, 32'h0);
        apb(1'b1, `TMB_OFF_CMP0, 32'h1);
        apb(1'b1, `TMB_OFF_MODE, 32'h5);
        apb(1'b1, `TMB_OFF_FFCR, 32'h1f);
        apb(1'b1, `TMB_OFF_CMP0, 32'h2);
        rdchk(`TMB_OFF_CMP0, 32'h1);
        apb(1'b1, `TMB_OFF_RUN, 32'h5);
        wait_c1(a);
        rdchk(`TMB_OFF_CMP0, 32'h2);
        wait_c1(a);
        t = n_tog;
        wait_c1(a);
        chk(n_tog - t, 2);
        apb(1'b1, `TMB_OFF_FFCR, 32'h3);
    endtask : t_ppg
    // watchdog
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        test_done;
    end
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = 32'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs;
        t_flop;
        t_interval;
        t_event;
        t_pins;
        t_in0_edges;
        t_companion;
        t_ppg;
        test_done;
    end
endmodule : tmb_channel_tb
`default_nettype wire
